// [logic/aprp_device.sv]
// Behaviour
// - interface select low picks parallel bus
// - word/byte select: 0 word, 1 byte
// - parallel reads skip unconverted pairs
// - serial mode also skips unconverted channels and never drives the bus
// - start strobe rising edge begins conversion
// - internal timer, conversion lasts 3 us
// - busy falls at completion, back to track
// - strobe a/b/c convert pairs 1-2/3-4/5-6
// - rising strobes ignored while busy high
// - bus driven only with cs and rd low; enables follow the synchronised cs and rd, two cycles late
// - cs may stay low, rd alone gates
// - host reads after busy low, one per channel
// - results read in ascending channel order
// - host avoids converting during read sequence
// - byte mode: two reads per result, upper lanes
// - byte order low gives low byte first
// - host ignores lower data lines in byte mode
// - busy high through whole conversion
`timescale 1ns/100ps
`default_nettype none
module aprp_device
#(
  parameter int CONV_CNT = aprp_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // host-facing pins
  aprp_if.dev pins,
  // converter core side: sample words for the six channels
  input wire logic [aprp_pkg::RESULT_W*aprp_pkg::CHANNELS-1:0] sample_data,
  output logic track_mode
);
  import aprp_pkg::*;

  // two-flop synchronisers for all pins coming from the host
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  wire [7:0] pin_raw = {pins.start_strobe_pair_c, pins.start_strobe_pair_b, pins.start_strobe_pair_a,
    pins.interface_select, pins.word_byte_select, pins.byte_order_select, pins.cs_n, pins.rd_n};
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 8'hff;
      sync2_reg <= 8'hff;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end
  wire [2:0] strobe_s = sync2_reg[7:5];
  wire parallel_s = sync2_reg[4] == IF_PARALLEL;
  wire byte_mode_s = sync2_reg[3] == MODE_BYTE;
  wire order_s = sync2_reg[2];
  wire cs_n_s = sync2_reg[1];
  wire rd_n_s = sync2_reg[0];

  // edge history for strobes and the read strobe
  logic [2:0] strobe_d_reg;
  logic rd_n_d_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_d_reg <= 3'h7;
      rd_n_d_reg <= 1'b1;
    end else begin
      strobe_d_reg <= strobe_s;
      rd_n_d_reg <= rd_n_s;
    end
  end
  wire [2:0] strobe_rise = strobe_s & ~strobe_d_reg;
  wire read_active = !rd_n_s && !cs_n_s;
  wire read_end = !rd_n_d_reg && rd_n_s && !cs_n_s;

  typedef enum logic [0:0] {APRP_TRACK, APRP_CONVERT} aprp_state_e;
  aprp_state_e state_reg;
  logic [$clog2(CONV_CNT+1)-1:0] conv_cnt_reg;
  logic [2:0] pairs_reg;
  logic [RESULT_W*CHANNELS-1:0] held_reg;
  wire start_ok = state_reg == APRP_TRACK && strobe_rise != PAIRS_NONE;
  wire conv_done = state_reg == APRP_CONVERT && conv_cnt_reg == 1'b1;

  // conversion timer from the internal clock, results latched at the end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= APRP_TRACK;
      conv_cnt_reg <= '0;
      pairs_reg <= PAIRS_NONE;
      held_reg <= '0;
    end else begin
      unique case (state_reg)
        APRP_TRACK: begin
          if (start_ok) begin
            state_reg <= APRP_CONVERT;
            pairs_reg <= strobe_rise;
            conv_cnt_reg <= ($bits(conv_cnt_reg))'(CONV_CNT);
          end
        end
        APRP_CONVERT: begin
          conv_cnt_reg <= conv_cnt_reg - 1'b1;
          if (conv_done) begin
            state_reg <= APRP_TRACK;
            held_reg <= sample_data;
          end
        end
      endcase
    end
  end
  assign pins.busy = state_reg == APRP_CONVERT;
  assign track_mode = state_reg == APRP_TRACK;

  // serial view: unconverted channels become zeros
  logic [RESULT_W*CHANNELS-1:0] zero_filled;
  genvar gp;
  generate
    for (gp = 0; gp < PAIRS; gp++) begin : g_pair
      assign zero_filled[gp*2*RESULT_W +: 2*RESULT_W] =
        pairs_reg[gp] ? held_reg[gp*2*RESULT_W +: 2*RESULT_W] : '0;
    end
  endgenerate

  // fill side: walk converted channels in ascending order into the fifo
  logic [2:0] fill_chan_reg;
  logic filling_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [RESULT_W-1:0] fifo_out_data;
  logic flush_reg;
  wire fill_valid = filling_reg && pairs_reg[fill_chan_reg[2:1]];
  // no step while flushing, else the first converted word would be skipped unpushed
  wire fill_step = filling_reg && !flush_reg && (!pairs_reg[fill_chan_reg[2:1]] || fifo_in_ready);
  wire [RESULT_W-1:0] fill_word = parallel_s ? held_reg[fill_chan_reg*RESULT_W +: RESULT_W]
    : zero_filled[fill_chan_reg*RESULT_W +: RESULT_W];
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fill_chan_reg <= CHAN_FIRST;
      filling_reg <= 1'b0;
    end else if (conv_done) begin
      fill_chan_reg <= CHAN_FIRST;
      filling_reg <= 1'b1;
    end else if (fill_step) begin
      fill_chan_reg <= fill_chan_reg + 3'h1;
      filling_reg <= fill_chan_reg != 3'(CHANNELS-1);
    end
  end

  // drain side pops on end of read; flushes old words on new completion
  logic byte_sel_reg;
  wire last_part = !byte_mode_s || byte_sel_reg;
  wire pop = flush_reg || (read_end && last_part);
  aprp_fifo #(.WIDTH(RESULT_W), .DEPTH(4)) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(fill_valid && !flush_reg),
    .in_ready(fifo_in_ready),
    .in_data(fill_word),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flush_reg <= 1'b0;
      byte_sel_reg <= 1'b0;
    end else begin
      if (conv_done) flush_reg <= 1'b1;
      else if (!fifo_out_valid) flush_reg <= 1'b0;
      if (conv_done) byte_sel_reg <= 1'b0;
      else if (read_end && byte_mode_s) byte_sel_reg <= !byte_sel_reg;
    end
  end

  // output data register; byte mode uses the upper lanes only
  wire hi_first = order_s != ORDER_LOW_FIRST;
  wire take_high = hi_first ^ byte_sel_reg;
  wire [7:0] byte_pick = take_high ? fifo_out_data[15:8] : fifo_out_data[7:0];
  logic [15:0] db_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      db_reg <= RESULT_RESET;
    end else begin
      db_reg <= byte_mode_s ? {byte_pick, 8'h00} : fifo_out_data;
    end
  end
  assign pins.db_out = db_reg;
  assign pins.db_oe = (read_active && parallel_s) ? 16'hffff : 16'h0000;
endmodule
`default_nettype wire

// [pkg/aprp_pkg.sv]
`default_nettype none
package aprp_pkg;
  // conversion timing at the 50 MHz core clock
  localparam int CLK_MHZ = 50;
  localparam int CONV_TIME_NS = 3000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CHANNELS = 6;
  localparam int PAIRS = 3;
  localparam int RESULT_W = 16;
  localparam int BYTE_W = 8;
  // interface select level that picks the parallel bus
  localparam logic IF_PARALLEL = 1'b0;
  localparam logic MODE_WORD = 1'b0;
  localparam logic MODE_BYTE = 1'b1;
  localparam logic ORDER_LOW_FIRST = 1'b0;
  localparam logic [2:0] PAIRS_NONE = 3'h0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [2:0] CHAN_FIRST = 3'h0;
  // host read strobe width and gap in core cycles, less one (each phase lasts 3 cycles)
  localparam int HOST_RD_CYCLES = 2;
  // host gap after busy falls; covers the device flush and skip of unconverted pairs
  localparam int HOST_SETTLE_CYCLES = 10;
endpackage
`default_nettype wire

// [pkg/aprp_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface aprp_if;
  logic start_strobe_pair_a;
  logic start_strobe_pair_b;
  logic start_strobe_pair_c;
  logic interface_select;
  logic word_byte_select;
  logic byte_order_select;
  logic cs_n;
  logic rd_n;
  logic busy;
  logic [15:0] db_out;
  logic [15:0] db_oe;
  modport dev (
    input start_strobe_pair_a, start_strobe_pair_b, start_strobe_pair_c,
    input interface_select, word_byte_select, byte_order_select, cs_n, rd_n,
    output busy, db_out, db_oe
  );
  modport host (
    output start_strobe_pair_a, start_strobe_pair_b, start_strobe_pair_c,
    output interface_select, word_byte_select, byte_order_select, cs_n, rd_n,
    input busy, db_out, db_oe
  );
endinterface
`default_nettype wire

// [logic/aprp_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module aprp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = count_reg != (AW+1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign out_data = mem[rd_ptr_reg];
  // storage only, no reset needed
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
  // pointers wrap since depth is a power of two
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop) count_reg <= count_reg + 1'b1;
      else if (pop && !push) count_reg <= count_reg - 1'b1;
    end
  end
endmodule
`default_nettype wire

// [logic/aprp_host.sv]
`timescale 1ns/100ps
`default_nettype none
module aprp_host
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // device pins
  aprp_if.host pins,
  // user command side
  input wire logic [2:0] start_pairs,
  input wire logic start_req,
  input wire logic byte_mode,
  input wire logic high_first,
  output logic ready,
  // result stream
  output logic result_valid,
  output logic [15:0] result_data
);
  import aprp_pkg::*;

  // busy comes from the device and is synchronised
  logic busy_s1_reg;
  logic busy_s2_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
    end else begin
      busy_s1_reg <= pins.busy;
      busy_s2_reg <= busy_s1_reg;
    end
  end

  typedef enum logic [2:0] {H_IDLE, H_STROBE, H_WAIT_HI, H_WAIT_LO, H_SETTLE, H_RD_LO, H_RD_HI} aprp_hstate_e;
  aprp_hstate_e st_reg;
  logic [2:0] pairs_reg;
  logic [3:0] reads_left_reg;
  logic [3:0] tmr_reg;
  logic [3:0] settle_reg;
  logic part_reg;
  logic [15:0] data_reg;
  logic mode_reg;
  logic order_reg;
  wire [3:0] words = 4'({pairs_reg[0], 1'b0}) + 4'({pairs_reg[1], 1'b0}) + 4'({pairs_reg[2], 1'b0});
  wire tmr_done = tmr_reg == 4'(HOST_RD_CYCLES);
  wire settle_done = settle_reg == 4'(HOST_SETTLE_CYCLES);

  // strobe, wait for busy, then read in order; no starts while reading
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= H_IDLE;
      pairs_reg <= PAIRS_NONE;
      reads_left_reg <= '0;
      tmr_reg <= '0;
      settle_reg <= '0;
      part_reg <= 1'b0;
      data_reg <= '0;
      result_valid <= 1'b0;
      result_data <= '0;
      mode_reg <= MODE_WORD;
      order_reg <= ORDER_LOW_FIRST;
    end else begin
      result_valid <= 1'b0;
      tmr_reg <= tmr_done ? 4'h0 : tmr_reg + 4'h1;
      unique case (st_reg)
        H_IDLE: if (start_req && start_pairs != PAIRS_NONE) begin
          pairs_reg <= start_pairs;
          mode_reg <= byte_mode;
          order_reg <= high_first;
          tmr_reg <= '0;
          st_reg <= H_STROBE;
        end
        H_STROBE: if (tmr_done) st_reg <= H_WAIT_HI;
        H_WAIT_HI: if (busy_s2_reg) st_reg <= H_WAIT_LO;
        H_WAIT_LO: if (!busy_s2_reg) begin
          reads_left_reg <= mode_reg ? 4'(words << 1) : words;
          part_reg <= 1'b0;
          settle_reg <= '0;
          st_reg <= H_SETTLE;
        end
        // let the device stage the first word before the first strobe
        H_SETTLE: begin
          settle_reg <= settle_reg + 4'h1;
          if (settle_done) begin
            tmr_reg <= '0;
            st_reg <= H_RD_LO;
          end
        end
        H_RD_LO: if (tmr_done) begin
          // sample late in the strobe, after the device flops settle
          if (mode_reg) begin
            // low byte comes when the part matches the order select
            if (part_reg ^ order_reg) data_reg[15:8] <= pins.db_out[15:8];
            else data_reg[7:0] <= pins.db_out[15:8];
          end else begin
            data_reg <= pins.db_out;
          end
          st_reg <= H_RD_HI;
        end
        H_RD_HI: if (tmr_done) begin
          reads_left_reg <= reads_left_reg - 4'h1;
          part_reg <= !part_reg;
          if (!mode_reg || part_reg) begin
            result_valid <= 1'b1;
            result_data <= data_reg;
          end
          st_reg <= (reads_left_reg == 4'h1) ? H_IDLE : H_RD_LO;
        end
      endcase
    end
  end
  assign ready = st_reg == H_IDLE;
  assign pins.start_strobe_pair_a = !(st_reg == H_STROBE && pairs_reg[0]);
  assign pins.start_strobe_pair_b = !(st_reg == H_STROBE && pairs_reg[1]);
  assign pins.start_strobe_pair_c = !(st_reg == H_STROBE && pairs_reg[2]);
  assign pins.interface_select = IF_PARALLEL;
  assign pins.word_byte_select = mode_reg;
  assign pins.byte_order_select = order_reg;
  assign pins.cs_n = 1'b0;
  assign pins.rd_n = st_reg != H_RD_LO;
endmodule
`default_nettype wire

// [dv/aprp_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module aprp_properties #(
  parameter int CONV_CNT = 150
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // host driven pins
  input wire logic start_strobe_pair_a,
  input wire logic start_strobe_pair_b,
  input wire logic start_strobe_pair_c,
  input wire logic interface_select,
  input wire logic cs_n,
  input wire logic rd_n,
  // device driven pins
  input wire logic busy,
  input wire logic [15:0] db_out,
  input wire logic [15:0] db_oe
);
  logic [2:0] strb_q;
  logic [15:0] busy_cnt;
  logic [3:0] since_rise;
  wire logic [2:0] strb = {start_strobe_pair_c, start_strobe_pair_b, start_strobe_pair_a};
  wire logic strb_rise = |(strb & ~strb_q);
  wire logic rise_sat = (since_rise == 4'hf);
  // since_rise saturates so a long idle gap never wraps back to small values
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strb_q <= 3'h7;
      busy_cnt <= 16'h0000;
      since_rise <= 4'hf;
    end else begin
      strb_q <= strb;
      busy_cnt <= busy ? busy_cnt + 16'h0001 : 16'h0000;
      since_rise <= strb_rise ? 4'h0 : (rise_sat ? since_rise : since_rise + 4'h1);
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_OE_WHOLE_BUS: assert property (db_oe == 16'h0000 || db_oe == 16'hffff)
    else $error("data bus enables split");
  AST_OE_NEEDS_READ: assert property ((rd_n || cs_n)[*4] |-> db_oe == 16'h0000)
    else $error("data bus driven without read");
  AST_OE_PARALLEL_ONLY: assert property (db_oe != 16'h0000 |-> interface_select == aprp_pkg::IF_PARALLEL)
    else $error("data bus driven outside parallel mode");
  AST_NO_READ_WHILE_BUSY: assert property (!rd_n |-> !busy)
    else $error("read during conversion");
  AST_NO_START_IN_READ: assert property (!rd_n |-> strb == 3'h7)
    else $error("start strobe during read");
  AST_STROBE_PULSE: assert property (strb != 3'h7 |-> ##[1:8] strb == 3'h7)
    else $error("start strobe never returned high");
  AST_BUSY_AFTER_START: assert property ($rose(busy) |-> since_rise <= 4'h8)
    else $error("busy rose without a strobe rise");
  AST_CONV_LENGTH: assert property ($fell(busy) |-> busy_cnt == CONV_CNT)
    else $error("conversion length wrong");
  AST_NO_RESTART: assert property (busy |-> busy_cnt < CONV_CNT)
    else $error("busy extended past one conversion");
  AST_WORD_STEADY: assert property ((!rd_n)[*2] |=> (rd_n || $stable(db_out)))
    else $error("read word changed mid read");

  // main scenarios seen
  cover property ($fell(busy));
  cover property (!rd_n && db_oe == 16'hffff);
  cover property ($rose(busy) && strb_q != 3'h7);
endmodule
`default_nettype wire

// [dv/adc_parallel_readout_port_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module adc_parallel_readout_port_tb;
  import aprp_pkg::*;
  // short conversion keeps the run small
  localparam int CONV_CNT = 10;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] start_pairs = 3'h0;
  logic start_req = 1'b0;
  logic byte_mode = 1'b0;
  logic high_first = 1'b0;
  logic [RESULT_W*CHANNELS-1:0] sample_data = '0;
  logic ready;
  logic result_valid;
  logic [15:0] result_data;
  logic track_mode;
  logic rd_q = 1'b1;
  logic [15:0] wire_q[$];
  int n_fail = 0;
  int comparisons = 0;

  aprp_if bus();
  aprp_device #(.CONV_CNT(CONV_CNT)) i_aprp_device (.core_clk(core_clk), .reset_n(reset_n), .pins(bus),
    .sample_data(sample_data), .track_mode(track_mode));
  aprp_host i_aprp_host (.core_clk(core_clk), .reset_n(reset_n), .pins(bus), .start_pairs(start_pairs),
    .start_req(start_req), .byte_mode(byte_mode), .high_first(high_first), .ready(ready),
    .result_valid(result_valid), .result_data(result_data));
  aprp_properties #(.CONV_CNT(CONV_CNT)) i_aprp_properties (.core_clk(core_clk), .reset_n(reset_n),
    .start_strobe_pair_a(bus.start_strobe_pair_a), .start_strobe_pair_b(bus.start_strobe_pair_b),
    .start_strobe_pair_c(bus.start_strobe_pair_c), .interface_select(bus.interface_select),
    .cs_n(bus.cs_n), .rd_n(bus.rd_n), .busy(bus.busy), .db_out(bus.db_out), .db_oe(bus.db_oe));

  always #10 core_clk = ~core_clk;

  // bus monitor: enables lag the strobe, so the word is still shown as rd_n rises
  always @(posedge core_clk) begin
    rd_q <= bus.rd_n;
    if (bus.rd_n && !rd_q && bus.db_oe[15])
      wire_q.push_back(bus.db_out);
  end

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one conversion, then judge the result stream and the words on the bus
  task automatic do_conv(input logic [2:0] pairs, input logic bm, input logic hf, input logic [15:0] base_word);
    logic [15:0] exp_q[$];
    logic [15:0] got_q[$];
    logic [15:0] w;
    int k;
    @(posedge core_clk);
    // distinct word per channel so any order slip shows
    for (k = 0; k < CHANNELS; k++) begin
      w = base_word + 16'(k) * 16'h1111;
      sample_data[k*16 +: 16] <= w;
      if (pairs[k/2])
        exp_q.push_back(w);
    end
    byte_mode <= bm;
    high_first <= hf;
    start_pairs <= pairs;
    wire_q.delete();
    k = 0;
    while (ready !== 1'b1 && k < 200) begin
      @(negedge core_clk);
      k++;
    end
    @(posedge core_clk);
    start_req <= 1'b1;
    @(posedge core_clk);
    start_req <= 1'b0;
    k = 0;
    while (bus.busy !== 1'b1 && k < 50) begin
      @(negedge core_clk);
      k++;
    end
    `CHK("track_mode in conversion", 1'b0, track_mode)
    k = 0;
    while (got_q.size() < exp_q.size() && k < 3000) begin
      @(negedge core_clk);
      k++;
      if (result_valid === 1'b1)
        got_q.push_back(result_data);
    end
    repeat (8) @(negedge core_clk);
    `CHK("result count", exp_q.size(), got_q.size())
    for (k = 0; k < exp_q.size() && k < got_q.size(); k++)
      `CHK("result word", exp_q[k], got_q[k])
    `CHK("bus reads", exp_q.size() * (bm ? 2 : 1), wire_q.size())
    for (k = 0; k < wire_q.size() && k < 12; k++) begin
      w = exp_q[bm ? k / 2 : k];
      if (!bm)
        `CHK("bus word", w, wire_q[k])
      else
        `CHK("bus byte", (((k % 2) == 0) == hf) ? w[15:8] : w[7:0], wire_q[k][15:8])
    end
    `CHK("track_mode idle", 1'b1, track_mode)
  endtask

  // outer pairs only: middle pair skipped on the bus
  task automatic t_word_skip_middle();
    do_conv(3'b101, MODE_WORD, ORDER_LOW_FIRST, 16'h1234);
  endtask

  // each strobe alone converts only its own pair
  task automatic t_word_single_pairs();
    do_conv(3'b001, MODE_WORD, ORDER_LOW_FIRST, 16'h0a10);
    do_conv(3'b010, MODE_WORD, ORDER_LOW_FIRST, 16'h0b20);
    do_conv(3'b100, MODE_WORD, ORDER_LOW_FIRST, 16'h0c30);
  endtask

  // back to back full conversions, pointer must restart at channel one
  task automatic t_word_all_twice();
    do_conv(3'b111, MODE_WORD, ORDER_LOW_FIRST, 16'h0f00);
    do_conv(3'b111, MODE_WORD, ORDER_LOW_FIRST, 16'h5a5a);
  endtask

  // byte mode, all six channels in twelve reads, low byte first
  task automatic t_byte_low_first();
    do_conv(3'b111, MODE_BYTE, ORDER_LOW_FIRST, 16'hc3a0);
  endtask

  // byte mode with high byte first on one pair
  task automatic t_byte_high_first();
    do_conv(3'b010, MODE_BYTE, ~ORDER_LOW_FIRST, 16'h8001);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    t_word_skip_middle();
    t_word_single_pairs();
    t_word_all_twice();
    t_byte_low_first();
    t_byte_high_first();
    stop_test();
  end

  // the whole run needs well under a thousand cycles; far past that is a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
